// >>> design/fie_bank.sv
// Fault interrupt-enable bank behind a classic Wishbone slave
// How it works
// RQ1 - Each enable field reads 0h when disabled, 2h when enabled.
// RQ2 - Writing 1h disables a field, writing 3h enables it.
// RQ3 - Writing 0h or 2h keeps the field's state unchanged.
// RQ4 - Input over-voltage enable is supply bits 3-2, resets enabled.
// RQ5 - Input under-voltage enable is supply bits 1-0, resets enabled.
// RQ6 - Primary register at 50h resets A02Ah; master 15-14, temperature 11-10.
// RQ7 - Boost overvoltage-high enable is primary bits 13-12, resets enabled.
// RQ8 - Boost overvoltage-low enable is primary bits 7-6, resets disabled.
// RQ9 - Boost overcurrent enable is primary bits 5-4, resets enabled.
// RQ10 - Supply lockout enable is primary bits 3-2, resets enabled.
// RQ11 - Thermal shutdown enable is primary bits 1-0, resets enabled.
// RQ12 - LED register at 52h resets 80h; string enable in bits 7-6.
// RQ13 - String open/short enable gates LED string fault interrupts; the code gates fault_irq_o but not event_irq_o.
// RQ14 - Reserved bits reset to zero and have no function.
// RQ15 - Fault pin needs master enable, a set fault and its own enable.
// RQ16 - Supply register at 4Eh resets 200Ah.
// RQ17 - Software clears a fault by writing its status and clear bits.
`timescale 1ns/1ps
module fie_bank
	import fie_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [fie_aw+1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [fie_dw-1:0] dat_i,
	output logic [fie_dw-1:0] dat_o,
	output logic ack_o,
	output logic err_o,
	// Latched fault levels from the fault status logic
	input wire logic [fie_nsrc-1:0] fault_i,
	// Interrupts
	output logic fault_irq_o,
	output logic event_irq_o
);

	function automatic logic [15:0] place(input logic [1:0] v, input int p);
		place = 16'({14'h0000, v} << p);
	endfunction : place

	function automatic logic [1:0] rd_code(input logic on);
		rd_code = on ? fie_rd_on : fie_rd_off;
	endfunction : rd_code

	logic req;
	logic [7:0] idx;
	logic wr;
	logic rd;
	logic wr_lo;
	logic wr_hi;
	logic [15:0] wdat;
	logic wr_pri;
	logic wr_led;
	logic wr_sup;
	logic [fie_nsrc-1:0] allow;
	logic [1:0] code [fie_nsrc];
	logic [fie_nsrc-1:0] wr_f;
	logic [1:0] cmd_f [fie_nsrc];
	logic [1:0] glb_code;
	logic glb_on;
	logic [15:0] primary;
	logic [15:0] led;
	logic [15:0] supply;
	logic [fie_nsrc-1:0] status;
	logic [fie_nsrc-1:0] mask;
	logic [fie_nsrc-1:0] fault_q;
	logic [fie_nsrc-1:0] rise;
	logic next_irq;
	logic rd_status;

	assign req = cyc_i && stb_i && !ack_o && !err_o;
	assign idx = adr_i[fie_aw+1:2];
	assign wr = req && we_i;
	assign rd = req && !we_i;
	assign wr_lo = sel_i[0];
	assign wr_hi = sel_i[1];
	assign wdat = dat_i[15:0];
	assign wr_pri = wr && idx == fie_idx_primary;
	assign wr_led = wr && idx == fie_idx_led;
	assign wr_sup = wr && idx == fie_idx_supply;

	// Field position, register and byte lane per source
	int pos [fie_nsrc];
	always_comb begin
		pos[fie_src_tsd] = fie_pos_tsd;
		pos[fie_src_uvlo] = fie_pos_uvlo;
		pos[fie_src_ocp] = fie_pos_ocp;
		pos[fie_src_ovpl] = fie_pos_ovpl;
		pos[fie_src_temp] = fie_pos_temp;
		pos[fie_src_ovph] = fie_pos_ovph;
		pos[fie_src_led] = fie_pos_led;
		pos[fie_src_vinuvp] = fie_pos_vinuvp;
		pos[fie_src_vinovp] = fie_pos_vinovp;
		pos[fie_src_invstr] = fie_pos_invstr;
		pos[fie_src_fset] = fie_pos_fset;
		pos[fie_src_cp] = fie_pos_cp;
		pos[fie_src_cpcap] = fie_pos_cpcap;
		pos[fie_src_vinocp] = fie_pos_vinocp;
		pos[fie_src_bsync] = fie_pos_bsync;
	end

	always_comb begin
		for (int s = 0; s < fie_nsrc; s++) begin
			cmd_f[s] = 2'(wdat >> pos[s]);
			wr_f[s] = (pos[s] < 8) ? wr_lo : wr_hi;
			if (s < fie_src_led) begin
				wr_f[s] = wr_f[s] && wr_pri;
			end else if (s == fie_src_led) begin
				wr_f[s] = wr_f[s] && wr_led;
			end else begin
				wr_f[s] = wr_f[s] && wr_sup;
			end
		end
	end

	// Reset states: enabled ones per the documented reset words
	localparam logic [fie_nsrc-1:0] rst_on = 15'h21e7;

	genvar g;
	generate
		for (g = 0; g < fie_nsrc; g++) begin : gen_src
			fie_field #(.RST_ON(rst_on[g])) u_field ( // [RQ4] [RQ5] [RQ7]
				.clk_i(clk_i),
				.rst_i(rst_i),
				.wr_i(wr_f[g]),
				.cmd_i(cmd_f[g]),
				.on_o(allow[g]),
				.rd_o(code[g])
			);
		end
	endgenerate

	// Master enable
	fie_field #(.RST_ON(1'b1)) u_global ( // [RQ6]
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_i(wr_pri && wr_hi),
		.cmd_i(wdat[fie_pos_global +: 2]),
		.on_o(glb_on),
		.rd_o(glb_code)
	);

	// Read images; reserved bits fixed at zero [RQ14]
	always_comb begin
		primary = place(glb_code, fie_pos_global); // [RQ6]
		primary |= place(code[fie_src_ovph], fie_pos_ovph); // [RQ7]
		primary |= place(code[fie_src_temp], fie_pos_temp); // [RQ6]
		primary |= place(code[fie_src_ovpl], fie_pos_ovpl); // [RQ8]
		primary |= place(code[fie_src_ocp], fie_pos_ocp); // [RQ9]
		primary |= place(code[fie_src_uvlo], fie_pos_uvlo); // [RQ10]
		primary |= place(code[fie_src_tsd], fie_pos_tsd); // [RQ11]
		led = place(code[fie_src_led], fie_pos_led); // [RQ12]
		supply = place(code[fie_src_bsync], fie_pos_bsync); // [RQ16]
		supply |= place(code[fie_src_vinocp], fie_pos_vinocp);
		supply |= place(code[fie_src_cpcap], fie_pos_cpcap);
		supply |= place(code[fie_src_cp], fie_pos_cp);
		supply |= place(code[fie_src_fset], fie_pos_fset);
		supply |= place(code[fie_src_invstr], fie_pos_invstr);
		supply |= place(code[fie_src_vinovp], fie_pos_vinovp); // [RQ4]
		supply |= place(code[fie_src_vinuvp], fie_pos_vinuvp); // [RQ5]
	end

	// Bus answer: one-cycle ack, err on an unmapped index
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			dat_o <= '0;
		end else begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			if (req) begin
				unique case (idx)
					fie_idx_primary: begin
						ack_o <= 1'b1;
						dat_o <= {16'h0000, primary};
					end
					fie_idx_led: begin
						ack_o <= 1'b1;
						dat_o <= {16'h0000, led};
					end
					fie_idx_supply: begin
						ack_o <= 1'b1;
						dat_o <= {16'h0000, supply};
					end
					fie_idx_status: begin
						ack_o <= 1'b1;
						dat_o <= {17'h00000, status};
					end
					fie_idx_mask: begin
						ack_o <= 1'b1;
						dat_o <= {17'h00000, mask};
					end
					default: begin
						err_o <= 1'b1;
						dat_o <= '0;
					end
				endcase
			end
		end
	end

	// Fault pin: master and per-source enables gate latched faults
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_irq_o <= 1'b0;
		end else begin
			fault_irq_o <= glb_on && |(fault_i & allow); // [RQ15] [RQ13] [RQ17]
		end
	end

	// New-fault events: sticky, cleared by a status read, set wins
	assign rise = fault_i & ~fault_q;
	assign rd_status = rd && idx == fie_idx_status;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_q <= '0;
			status <= '0;
		end else begin
			fault_q <= fault_i;
			status <= (rd_status ? '0 : status) | rise;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask <= fie_rst_mask;
		end else if (wr && idx == fie_idx_mask) begin
			if (wr_lo) begin
				mask[7:0] <= wdat[7:0];
			end
			if (wr_hi) begin
				mask[fie_nsrc-1:8] <= wdat[fie_nsrc-1:8];
			end
		end
	end

	assign next_irq = |(status & mask);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			event_irq_o <= 1'b0;
		end else begin
			event_irq_o <= next_irq;
		end
	end

	// Checks
	reset_words_a: assert property (@(posedge clk_i) // [RQ6]
		$past(rst_i) && !rst_i |-> primary == fie_rst_primary &&
		led == fie_rst_led && supply == fie_rst_supply)
		else $error("enable registers wrong after reset");

	pin_gating_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ15]
		!rst_i |=> fault_irq_o ==
		($past(glb_on) && |($past(fault_i) & $past(allow))))
		else $error("fault pin not gated by enables");

	led_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ13]
		!allow[fie_src_led] && fault_i == (15'h0001 << fie_src_led)
		|=> !fault_irq_o)
		else $error("disabled string fault reached the pin");

	reserved_zero_a: assert property (@(posedge clk_i) // [RQ14]
		primary[9:8] == 2'h0 && led[15:8] == 8'h00 && led[5:0] == 6'h00)
		else $error("reserved enable bits not zero");

	read_code_a: assert property (@(posedge clk_i) // [RQ1]
		primary[15:14] == (glb_on ? fie_rd_on : fie_rd_off) &&
		supply[3:2] == (allow[fie_src_vinovp] ? fie_rd_on : fie_rd_off))
		else $error("enable field read code wrong");

	bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		req |=> (ack_o || err_o) ##1 !ack_o)
		else $error("bus answer timing wrong");

	global_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ2]
		wr_pri && wr_hi && wdat[15:14] == fie_cmd_off |=> ##1 !fault_irq_o)
		else $error("pin active after master disable");

	boost_codes_a: assert property (@(posedge clk_i) // [RQ7] [RQ8] [RQ9]
		primary[13:12] == rd_code(allow[fie_src_ovph]) &&
		primary[7:6] == rd_code(allow[fie_src_ovpl]) &&
		primary[5:4] == rd_code(allow[fie_src_ocp]))
		else $error("boost enable read code wrong");

	lockout_codes_a: assert property (@(posedge clk_i) // [RQ10] [RQ11]
		primary[3:2] == rd_code(allow[fie_src_uvlo]) &&
		primary[1:0] == rd_code(allow[fie_src_tsd]))
		else $error("lockout or shutdown read code wrong");

	temp_code_a: assert property (@(posedge clk_i) // [RQ6]
		primary[11:10] == rd_code(allow[fie_src_temp]))
		else $error("temperature enable read code wrong");

	string_code_a: assert property (@(posedge clk_i) // [RQ12] [RQ13]
		led[7:6] == rd_code(allow[fie_src_led]))
		else $error("string enable read code wrong");

	undervolt_code_a: assert property (@(posedge clk_i) // [RQ5]
		supply[1:0] == rd_code(allow[fie_src_vinuvp]))
		else $error("under-voltage enable read code wrong");

	read_data_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ1]
		rd && idx == fie_idx_primary |=>
		ack_o && dat_o == {16'h0000, $past(primary)})
		else $error("primary read data wrong");

	lane_guard_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_pri && !wr_hi |=> $stable(primary[15:8]))
		else $error("unselected byte lane was written");

	unmapped_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
		req && idx != fie_idx_primary && idx != fie_idx_led &&
		idx != fie_idx_supply |=>
		$stable(primary) && $stable(led) && $stable(supply))
		else $error("enable registers changed by another index");

	answer_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!(ack_o && err_o))
		else $error("ack and err raised together");

	data_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dat_o[31:16] == 16'h0000)
		else $error("read data upper half not zero");

	event_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		|rise |=> (status & $past(rise)) == $past(rise))
		else $error("new fault event not recorded");

	event_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_status && rise == '0 |=> status == '0)
		else $error("status read did not clear events");

	event_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!rst_i |=> event_irq_o == $past(next_irq))
		else $error("event pin does not follow masked status");

endmodule : fie_bank

// >>> design/fie_pkg.sv
// Package of offsets, field positions and reset values for the enable bank
package fie_pkg;

	localparam int fie_aw = 8;
	localparam int fie_dw = 32;

	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] fie_idx_supply = 8'h4e;
	localparam logic [7:0] fie_idx_primary = 8'h50;
	localparam logic [7:0] fie_idx_led = 8'h52;
	localparam logic [7:0] fie_idx_status = 8'h60;
	localparam logic [7:0] fie_idx_mask = 8'h61;

	// Reset values
	localparam logic [15:0] fie_rst_supply = 16'h200a;
	localparam logic [15:0] fie_rst_primary = 16'ha02a;
	localparam logic [15:0] fie_rst_led = 16'h0080;

	// Write commands and read codes of a 2-bit enable field
	localparam logic [1:0] fie_cmd_off = 2'h1;
	localparam logic [1:0] fie_cmd_on = 2'h3;
	localparam logic [1:0] fie_rd_off = 2'h0;
	localparam logic [1:0] fie_rd_on = 2'h2;

	// Field low-bit positions, primary register
	localparam int fie_pos_global = 14;
	localparam int fie_pos_ovph = 12;
	localparam int fie_pos_temp = 10;
	localparam int fie_pos_ovpl = 6;
	localparam int fie_pos_ocp = 4;
	localparam int fie_pos_uvlo = 2;
	localparam int fie_pos_tsd = 0;
	// LED register
	localparam int fie_pos_led = 6;
	// Supply register
	localparam int fie_pos_bsync = 14;
	localparam int fie_pos_vinocp = 12;
	localparam int fie_pos_cpcap = 10;
	localparam int fie_pos_cp = 8;
	localparam int fie_pos_fset = 6;
	localparam int fie_pos_invstr = 4;
	localparam int fie_pos_vinovp = 2;
	localparam int fie_pos_vinuvp = 0;

	// Fault source count and bit order of fault inputs and event status
	localparam int fie_nsrc = 15;
	localparam int fie_src_tsd = 0;
	localparam int fie_src_uvlo = 1;
	localparam int fie_src_ocp = 2;
	localparam int fie_src_ovpl = 3;
	localparam int fie_src_temp = 4;
	localparam int fie_src_ovph = 5;
	localparam int fie_src_led = 6;
	localparam int fie_src_vinuvp = 7;
	localparam int fie_src_vinovp = 8;
	localparam int fie_src_invstr = 9;
	localparam int fie_src_fset = 10;
	localparam int fie_src_cp = 11;
	localparam int fie_src_cpcap = 12;
	localparam int fie_src_vinocp = 13;
	localparam int fie_src_bsync = 14;

	localparam logic [fie_nsrc-1:0] fie_rst_mask = 15'h0000;

endpackage : fie_pkg

// >>> design/fie_field.sv
// One 2-bit interrupt-enable field with command-style writes
`timescale 1ns/1ps
module fie_field
	import fie_pkg::*;
#(
	parameter logic RST_ON = 1'b0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Write side
	input wire logic wr_i,
	input wire logic [1:0] cmd_i,
	// State
	output logic on_o,
	output logic [1:0] rd_o
);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			on_o <= RST_ON;
		end else if (wr_i && cmd_i == fie_cmd_off) begin
			on_o <= 1'b0; // [RQ2]
		end else if (wr_i && cmd_i == fie_cmd_on) begin
			on_o <= 1'b1; // [RQ2]
		end
		// 0h and 2h leave the state alone [RQ3]
	end

	assign rd_o = on_o ? fie_rd_on : fie_rd_off; // [RQ1]

	always_ff @(posedge clk_i) begin
		if (!rst_i && $past(!rst_i) && $past(wr_i)) begin
			cmd_effect_a: assert ((($past(cmd_i) == fie_cmd_on) -> on_o) && // [RQ2]
				(($past(cmd_i) == fie_cmd_off) -> !on_o))
				else $error("enable field ignored a command");
		end
		if (!rst_i && $past(!rst_i) && (!$past(wr_i) ||
			$past(cmd_i) == fie_cmd_off - 2'h1 ||
			$past(cmd_i) == fie_rd_on)) begin
			hold_state_a: assert (on_o == $past(on_o)) // [RQ3]
				else $error("enable field changed without a command");
		end
	end

endmodule : fie_field

// >>> sim/fie_bank_test.sv
// Self-checking bench for the fault interrupt-enable bank
`timescale 1ns/1ps
module fie_bank_test;
	import fie_pkg::*;
	typedef struct {logic err; logic chk; logic [31:0] d;} fie_note_t;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [9:0] adr_i = 10'h000;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h00000000;
	logic [31:0] dat_o;
	logic ack_o;
	logic err_o;
	logic [14:0] fault_i = 15'h0000;
	logic fault_irq_o;
	logic event_irq_o;
	fie_note_t notes[$];
	fie_note_t n;
	int error_cnt = 0;
	int num_checks = 0;
	logic [31:0] seed = 32'h0000000c;
	logic [15:0] shadow [3];
	logic [15:0] fmask [3] = '{16'hffff, 16'hfcff, 16'h00c0};
	logic [9:0] radr [3] = '{10'h138, 10'h140, 10'h148};
	logic [3:0] lanes = 4'h3;

	always #4 clk_i = ~clk_i;

	fie_bank fie_bank_inst (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .fault_i(fault_i),
		.fault_irq_o(fault_irq_o), .event_irq_o(event_irq_o)
	);

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// Command 1h clears a field to 0h, 3h sets it to 2h, 0h and 2h keep it
	function automatic logic [15:0] apply(logic [15:0] cur, logic [15:0] wd,
			logic [15:0] m);
		for (int i = 0; i < 16; i += 2) begin
			if (m[i] && wd[i])
				cur[i +: 2] = {wd[i+1], 1'b0};
		end
		return cur;
	endfunction : apply

	function automatic logic irq_exp(logic [14:0] f);
		logic [14:0] en;
		en = {shadow[0][15], shadow[0][13], shadow[0][11], shadow[0][9],
			shadow[0][7], shadow[0][5], shadow[0][3], shadow[0][1],
			shadow[2][7], shadow[1][13], shadow[1][11], shadow[1][7],
			shadow[1][5], shadow[1][3], shadow[1][1]};
		return shadow[1][15] && (|(f & en));
	endfunction : irq_exp

	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wb(logic we, logic [9:0] a, logic [31:0] wd, logic e,
			logic c, logic [31:0] x);
		int k;
		notes.push_back('{e, c, x});
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= we;
		adr_i <= a;
		sel_i <= lanes;
		dat_i <= wd;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && err_o !== 1'b1 && k < 20);
		if (k >= 20)
			check("bus answer", 32'h1, 32'h0);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb

	// Takes the oldest note whenever the slave answers
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 || err_o === 1'b1) begin
			if (notes.size() == 0) begin
				check("unexpected answer", 32'h1, 32'h0);
			end else begin
				n = notes.pop_front();
				check("err_o", {31'h0, n.err}, {31'h0, err_o});
				if (n.chk)
					check("dat_o", n.d, dat_o);
			end
		end
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict

	initial begin
		#100000;
		error_cnt++;
		print_verdict();
	end

	initial begin
		logic [15:0] w;
		logic [14:0] v;
		int r;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		shadow = '{16'h200a, 16'ha02a, 16'h0080};
		for (int i = 0; i < 3; i++) begin
			wb(0, radr[i], 0, 0, 1, {16'h0, shadow[i]});
		end
		wb(0, 10'h184, 0, 0, 1, 0);
		wb(0, 10'h180, 0, 0, 1, 0);
		wb(1, 10'h3fc, 32'hffff, 1, 0, 0);
		wb(0, 10'h154, 0, 1, 0, 0);
		wb(0, radr[1], 0, 0, 1, {16'h0, shadow[1]});
		// Commands 1h, 0h, 3h, 2h on every field of every register
		for (int i = 0; i < 3; i++) begin
			for (int c = 0; c < 4; c++) begin
				w = {8{2'(c ^ 1)}} & fmask[i];
				wb(1, radr[i], {16'h0, w}, 0, 0, 0);
				shadow[i] = apply(shadow[i], w, fmask[i]);
				wb(0, radr[i], 0, 0, 1, {16'h0, shadow[i]});
			end
		end
		// Random commands and fault levels against the fault pin
		for (int i = 0; i < 60; i++) begin
			r = int'(xs() % 3);
			w = 16'(xs()) & fmask[r];
			wb(1, radr[r], {16'h0, w}, 0, 0, 0);
			shadow[r] = apply(shadow[r], w, fmask[r]);
			wb(0, radr[r], 0, 0, 1, {16'h0, shadow[r]});
			w = 16'(xs());
			fault_i <= w[14:0];
			repeat (3) @(posedge clk_i);
			check("fault_irq_o", {31'h0, irq_exp(fault_i)},
				{31'h0, fault_irq_o});
		end
		// Low byte lane only: upper commands of the word are ignored
		lanes = 4'h1;
		wb(1, radr[1], 32'h5555, 0, 0, 0);
		shadow[1] = apply(shadow[1], 16'h5555, fmask[1] & 16'h00ff);
		lanes = 4'h3;
		wb(0, radr[1], 0, 0, 1, {16'h0, shadow[1]});
		// Lone string fault: pin follows it, drops when cleared, then gated
		wb(1, radr[1], 32'hc000, 0, 0, 0);
		wb(1, radr[2], 32'h00c0, 0, 0, 0);
		fault_i <= 15'h0040;
		repeat (3) @(posedge clk_i);
		check("fault_irq_o", 32'h1, {31'h0, fault_irq_o});
		fault_i <= 15'h0000;
		repeat (3) @(posedge clk_i);
		check("fault_irq_o", 32'h0, {31'h0, fault_irq_o});
		wb(1, radr[2], 32'h0040, 0, 0, 0);
		fault_i <= 15'h0040;
		repeat (3) @(posedge clk_i);
		check("fault_irq_o", 32'h0, {31'h0, fault_irq_o});
		// Event status with the mask open, then closed
		fault_i <= 15'h0;
		wb(0, 10'h180, 0, 0, 0, 0);
		wb(1, 10'h184, 32'h7fff, 0, 0, 0);
		w = 16'(xs());
		v = w[14:0] | 15'h1;
		fault_i <= v;
		repeat (3) @(posedge clk_i);
		check("event_irq_o", 32'h1, {31'h0, event_irq_o});
		wb(0, 10'h180, 0, 0, 1, {17'h0, v});
		repeat (2) @(posedge clk_i);
		check("event_irq_o", 32'h0, {31'h0, event_irq_o});
		wb(1, 10'h184, 32'h0, 0, 0, 0);
		fault_i <= 15'h0;
		repeat (2) @(posedge clk_i);
		fault_i <= v;
		repeat (3) @(posedge clk_i);
		check("event_irq_o", 32'h0, {31'h0, event_irq_o});
		wb(0, 10'h180, 0, 0, 1, {17'h0, v});
		repeat (3) @(posedge clk_i);
		// Reset in mid-run brings back the reset words and enables
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		shadow = '{16'h200a, 16'ha02a, 16'h0080};
		for (int i = 0; i < 3; i++) begin
			wb(0, radr[i], 0, 0, 1, {16'h0, shadow[i]});
		end
		check("fault_irq_o", {31'h0, irq_exp(fault_i)},
			{31'h0, fault_irq_o});
		print_verdict();
	end
endmodule : fie_bank_test
